// ---- rtl/link_delay_measurement_regs.sv ----
// Purpose: register bank for link delay measurements
// Assumes: measurement cores supply results on core_clk; pulses synchronous
// Notes: ack follows one cycle after cyc&stb; unmapped reads return zero
`timescale 1ns/1ps
`default_nettype none
module link_delay_measurement_regs
  import link_delay_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [RX_BUF_DEPTH-1:0] rx_fill_level,
  input wire logic rx_byte_offset,
  input wire logic line_rate_changed,
  output logic rx_pointer_realign_req,
  input wire ext_meas_t ext_meas,
  output logic [7:0] tx_period,
  output logic [7:0] rx_period,
  input wire logic tx_frame_pulse,
  input wire logic rx_frame_pulse,
  output logic irq
);
  // -----------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------
  logic ack_q;
  logic req, wr, rd;
  logic sel_rx, sel_tx, sel_rxe, sel_loop, sel_ist, sel_imk;
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign sel_rx = wb_adr_i == OFF_RX_STATUS;
  assign sel_tx = wb_adr_i == OFF_TX_EXT;
  assign sel_rxe = wb_adr_i == OFF_RX_EXT;
  assign sel_loop = wb_adr_i == OFF_LOOP;
  assign sel_ist = wb_adr_i == OFF_IRQ_STATUS;
  assign sel_imk = wb_adr_i == OFF_IRQ_MASK;

  logic realign_q, tx_upd_q, rx_upd_q;
  logic [7:0] tx_period_q, rx_period_q;
  logic [TX_RES_W-1:0] tx_res_q;
  logic [RX_BUF_DEPTH-1:0] rx_res_q;
  logic [LOOP_W-1:0] loop_q, loop_cnt_q;
  logic [IRQ_W-1:0] ist_q, imask_q;
  logic [31:0] rdata_q;
  loop_state_t lstate_q;
  logic loop_done;

  // -----------------------------------------------------------------
  // control
  // -----------------------------------------------------------------
  // R1: realign bit
  // R4: software write only; rate changes handled below
  always_ff @(posedge core_clk) begin
    if (rst) begin
      realign_q <= 1'b0;
      tx_period_q <= 8'h00;
      rx_period_q <= 8'h00;
      imask_q <= '0;
    end else begin
      if (wr && sel_rx && wb_sel_i[3])
        realign_q <= wb_dat_i[POS_REALIGN];
      // R7: tx period
      if (wr && sel_tx && wb_sel_i[3])
        tx_period_q <= wb_dat_i[POS_PERIOD+:8];
      // R10: rx period
      if (wr && sel_rxe && wb_sel_i[3])
        rx_period_q <= wb_dat_i[POS_PERIOD+:8];
      if (wr && sel_imk && wb_sel_i[0])
        imask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end
  // R3: rate change realigns without the bit
  // R2: no protection of in-flight data
  assign rx_pointer_realign_req = realign_q | line_rate_changed;
  assign tx_period = tx_period_q;
  assign rx_period = rx_period_q;

  // -----------------------------------------------------------------
  // extended delay results
  // -----------------------------------------------------------------
  logic rd_tx, rd_rx, rd_ist;
  assign rd_tx = rd & sel_tx;
  assign rd_rx = rd & sel_rxe;
  assign rd_ist = rd & sel_ist;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_upd_q <= 1'b0;
      rx_upd_q <= 1'b0;
      tx_res_q <= '0;
      rx_res_q <= '0;
    end else begin
      // R8: set wins over read clear
      if (ext_meas.tx_valid) begin
        tx_res_q <= ext_meas.tx_value;
        tx_upd_q <= 1'b1;
      end else if (rd_tx) begin
        tx_upd_q <= 1'b0;
      end
      // R11: set wins over read clear
      if (ext_meas.rx_valid) begin
        rx_res_q <= ext_meas.rx_value;
        rx_upd_q <= 1'b1;
      end else if (rd_rx) begin
        rx_upd_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // round-trip counter
  // -----------------------------------------------------------------
  logic [LOOP_W-1:0] loop_next;
  // saturate so a lost rx pulse reads as full scale, not a short delay
  assign loop_next = (loop_cnt_q == LOOP_MAX) ? LOOP_MAX :
                     loop_cnt_q + 20'h00001;
  // R13: count tx pulse to rx pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lstate_q <= LOOP_IDLE;
      loop_cnt_q <= '0;
      loop_q <= '0;
    end else begin
      case (lstate_q)
        LOOP_IDLE: begin
          if (tx_frame_pulse) begin
            loop_cnt_q <= '0;
            lstate_q <= LOOP_COUNT;
          end
        end
        LOOP_COUNT: begin
          if (rx_frame_pulse) begin
            // R14: one update per frame
            loop_q <= loop_next;
            lstate_q <= LOOP_IDLE;
          end else if (loop_cnt_q != LOOP_MAX) begin
            loop_cnt_q <= loop_cnt_q + 20'h00001;
          end
        end
        default: lstate_q <= LOOP_IDLE;
      endcase
    end
  end
  assign loop_done = (lstate_q == LOOP_COUNT) & rx_frame_pulse;

  // -----------------------------------------------------------------
  // interrupts
  // -----------------------------------------------------------------
  logic [IRQ_W-1:0] ev;
  assign ev = {loop_done, ext_meas.rx_valid, ext_meas.tx_valid};
  always_ff @(posedge core_clk) begin
    if (rst)
      ist_q <= '0;
    else if (rd_ist)
      ist_q <= ev;
    else
      ist_q <= ist_q | ev;
  end
  assign irq = |(ist_q & imask_q);

  // -----------------------------------------------------------------
  // read mux
  // -----------------------------------------------------------------
  // R15: reserved bits zero
  logic [31:0] w_rx, w_tx, w_rxe, w_loop, w_ist, w_imk, rmux;
  // R5: byte offset
  // R6: fill level
  assign w_rx = {7'h00, realign_q, 7'h00, rx_byte_offset,
                 {(16-RX_BUF_DEPTH){1'b0}}, rx_fill_level};
  // R9: tx result
  assign w_tx = {tx_period_q, tx_upd_q, 7'h00, tx_res_q};
  // R12: rx result width
  assign w_rxe = {rx_period_q, rx_upd_q, {(23-RX_BUF_DEPTH){1'b0}},
                  rx_res_q};
  assign w_loop = {12'h000, loop_q};
  assign w_ist = {{(32-IRQ_W){1'b0}}, ist_q};
  assign w_imk = {{(32-IRQ_W){1'b0}}, imask_q};
  assign rmux = sel_rx ? w_rx : sel_tx ? w_tx : sel_rxe ? w_rxe :
                sel_loop ? w_loop : sel_ist ? w_ist :
                sel_imk ? w_imk : RESET_WORD;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= RESET_WORD;
    end else begin
      ack_q <= req;
      if (rd)
        rdata_q <= rmux;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  property p_realign;
    @(posedge core_clk) disable iff (rst)
      wr && sel_rx && wb_sel_i[3] && wb_dat_i[POS_REALIGN]
      |=> rx_pointer_realign_req;
  endproperty
  a_realign: assert property (p_realign) // R1
    else $error("realign not raised");
  property p_rate;
    @(posedge core_clk) disable iff (rst)
      line_rate_changed |-> rx_pointer_realign_req;
  endproperty
  a_rate: assert property (p_rate) // R3
    else $error("rate change no realign");
  property p_txupd;
    @(posedge core_clk) disable iff (rst)
      ext_meas.tx_valid |=> tx_upd_q && tx_res_q == $past(ext_meas.tx_value);
  endproperty
  a_txupd: assert property (p_txupd) // R8
    else $error("tx update lost");
  property p_rxupd;
    @(posedge core_clk) disable iff (rst)
      ext_meas.rx_valid |=> rx_upd_q;
  endproperty
  a_rxupd: assert property (p_rxupd) // R11
    else $error("rx update lost");
  property p_txclr;
    @(posedge core_clk) disable iff (rst)
      rd_tx && !ext_meas.tx_valid |=> !tx_upd_q;
  endproperty
  a_txclr: assert property (p_txclr) // R8
    else $error("tx flag not cleared");
  property p_period;
    @(posedge core_clk) disable iff (rst)
      wr && sel_tx && wb_sel_i[3] |=> tx_period == $past(wb_dat_i[31:24]);
  endproperty
  a_period: assert property (p_period) // R7
    else $error("tx period not stored");
  sequence s_frame_end;
    lstate_q == LOOP_COUNT && rx_frame_pulse;
  endsequence
  property p_loop;
    @(posedge core_clk) disable iff (rst)
      s_frame_end ##0 loop_cnt_q != LOOP_MAX
      |=> loop_q == $past(loop_cnt_q) + 20'h00001;
  endproperty
  a_loop: assert property (p_loop) // R13
    else $error("loop value wrong");
  property p_loophold;
    @(posedge core_clk) disable iff (rst)
      !loop_done |=> $stable(loop_q);
  endproperty
  a_loophold: assert property (p_loophold) // R14
    else $error("loop changed mid frame");
  property p_resv;
    @(posedge core_clk) disable iff (rst)
      wb_ack_o && $past(sel_loop) && !$past(wb_we_i)
      |-> wb_dat_o[31:LOOP_W] == 12'h000;
  endproperty
  a_resv: assert property (p_resv) // R15
    else $error("reserved bits set");
  property p_ack;
    @(posedge core_clk) disable iff (rst)
      req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack timing");

  // -----------------------------------------------------------------
  // checks: reset and control
  // -----------------------------------------------------------------
  // no disable here: the reset itself is what is checked
  property p_rst_clear;
    @(posedge core_clk)
      rst |=> !wb_ack_o && wb_dat_o == RESET_WORD && tx_period == 8'h00
        && rx_period == 8'h00 && !irq && !realign_q;
  endproperty
  a_rst_clear: assert property (p_rst_clear) // R15
    else $error("state not cleared by reset");
  property p_realign_clr;
    @(posedge core_clk) disable iff (rst)
      wr && sel_rx && wb_sel_i[3] && !wb_dat_i[POS_REALIGN]
      |=> !rx_pointer_realign_req || line_rate_changed;
  endproperty
  a_realign_clr: assert property (p_realign_clr) // R1
    else $error("realign bit not cleared");
  property p_realign_keep;
    @(posedge core_clk) disable iff (rst)
      !(wr && sel_rx && wb_sel_i[3]) |=> realign_q == $past(realign_q);
  endproperty
  a_realign_keep: assert property (p_realign_keep) // R1
    else $error("realign bit changed without write");
  property p_period_rx;
    @(posedge core_clk) disable iff (rst)
      wr && sel_rxe && wb_sel_i[3] |=> rx_period == $past(wb_dat_i[31:24]);
  endproperty
  a_period_rx: assert property (p_period_rx) // R10
    else $error("rx period not stored");

  // -----------------------------------------------------------------
  // checks: read data
  // -----------------------------------------------------------------
  logic rd_unmapped;
  assign rd_unmapped = rd & ~(sel_rx | sel_tx | sel_rxe | sel_loop |
                              sel_ist | sel_imk);
  property p_rd_rx;
    @(posedge core_clk) disable iff (rst)
      rd && sel_rx |=> wb_dat_o[POS_BYTE_OFS] == $past(rx_byte_offset)
        && wb_dat_o[RX_BUF_DEPTH-1:0] == $past(rx_fill_level);
  endproperty
  a_rd_rx: assert property (p_rd_rx) // R5 R6
    else $error("rx status read wrong");
  property p_resv_rx;
    @(posedge core_clk) disable iff (rst)
      rd && sel_rx |=> wb_dat_o[31:25] == 7'h00 && wb_dat_o[23:17] == 7'h00
        && wb_dat_o[15:RX_BUF_DEPTH] == '0;
  endproperty
  a_resv_rx: assert property (p_resv_rx) // R15
    else $error("rx status reserved bits set");
  property p_rd_tx;
    @(posedge core_clk) disable iff (rst)
      rd && sel_tx |=> wb_dat_o[TX_RES_W-1:0] == $past(tx_res_q)
        && wb_dat_o[POS_UPDATED] == $past(tx_upd_q)
        && wb_dat_o[22:16] == 7'h00;
  endproperty
  a_rd_tx: assert property (p_rd_tx) // R9
    else $error("tx extended read wrong");
  property p_rd_rxe;
    @(posedge core_clk) disable iff (rst)
      rd && sel_rxe |=> wb_dat_o[RX_BUF_DEPTH-1:0] == $past(rx_res_q)
        && wb_dat_o[POS_UPDATED] == $past(rx_upd_q)
        && wb_dat_o[22:RX_BUF_DEPTH] == '0;
  endproperty
  a_rd_rxe: assert property (p_rd_rxe) // R12
    else $error("rx extended read wrong");
  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
      rd_unmapped |=> wb_dat_o == RESET_WORD;
  endproperty
  a_unmapped: assert property (p_unmapped) // R15
    else $error("unmapped read not zero");

  // -----------------------------------------------------------------
  // checks: results, flags and round trip
  // -----------------------------------------------------------------
  property p_rxres;
    @(posedge core_clk) disable iff (rst)
      ext_meas.rx_valid |=> rx_res_q == $past(ext_meas.rx_value);
  endproperty
  a_rxres: assert property (p_rxres) // R12
    else $error("rx result not stored");
  property p_rxclr;
    @(posedge core_clk) disable iff (rst)
      rd_rx && !ext_meas.rx_valid |=> !rx_upd_q;
  endproperty
  a_rxclr: assert property (p_rxclr) // R11
    else $error("rx flag not cleared");
  property p_txkeep;
    @(posedge core_clk) disable iff (rst)
      !rd_tx && !ext_meas.tx_valid
      |=> $stable(tx_upd_q) && $stable(tx_res_q);
  endproperty
  a_txkeep: assert property (p_txkeep) // R8
    else $error("tx flag or result changed alone");
  sequence s_frame_start;
    lstate_q == LOOP_IDLE && tx_frame_pulse;
  endsequence
  property p_loopstart;
    @(posedge core_clk) disable iff (rst)
      s_frame_start |=> lstate_q == LOOP_COUNT && loop_cnt_q == '0;
  endproperty
  a_loopstart: assert property (p_loopstart) // R13
    else $error("round trip count not started");
  property p_loopsat;
    @(posedge core_clk) disable iff (rst)
      s_frame_end ##0 loop_cnt_q == LOOP_MAX |=> loop_q == LOOP_MAX;
  endproperty
  a_loopsat: assert property (p_loopsat) // R13
    else $error("round trip value wrapped");
  property p_irq_set;
    @(posedge core_clk) disable iff (rst)
      ev != '0 |=> (ist_q & $past(ev)) == $past(ev);
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("event lost from irq status");
  property p_irq_clr;
    @(posedge core_clk) disable iff (rst)
      rd_ist && ev == '0
      |=> ist_q == '0 && wb_dat_o[IRQ_W-1:0] == $past(ist_q);
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("irq status not cleared by read");
endmodule // link_delay_measurement_regs
`default_nettype wire

// ---- rtl/link_delay_pkg.sv ----
// Purpose: constants and types for the link delay measurement registers
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register
// Notes: irq status and mask sit at 0x60 and 0x64, beside the delay words
// Operation
// R1: setting bit 24 forces a receive buffer pointer realignment.
// R2: a forced realignment may drop or corrupt buffered data.
// R3: a line rate change realigns receive pointers without software.
// R4: software uses bit 24 for drift, not for rate changes.
// R5: bit 16 reports the current receive byte-alignment offset.
// R6: low bits report receive buffer fill level in 32-bit words.
// R7: transmit integration period N sits in bits 31:24.
// R8: transmit update flag bit 23 sets on new result, read clears.
// R9: transmit extended delay result is 16 bits in bits 15:0.
// R10: receive integration period sits in bits 31:24.
// R11: receive update flag bit 23 sets on new result, read clears.
// R12: receive extended result field is buffer depth bits wide.
// R13: round-trip delay tx pulse to rx pulse, 20 bits in 19:0.
// R14: round-trip value refreshes once per radio frame.
// R15: reserved bits read zero, ignore writes; fields reset to zero.
package link_delay_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int RX_BUF_DEPTH = 4;
  localparam logic [7:0] OFF_RX_STATUS = 8'h4c;
  localparam logic [7:0] OFF_TX_EXT = 8'h50;
  localparam logic [7:0] OFF_RX_EXT = 8'h54;
  localparam logic [7:0] OFF_LOOP = 8'h58;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h60;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h64;
  localparam int POS_REALIGN = 24;
  localparam int POS_BYTE_OFS = 16;
  localparam int POS_PERIOD = 24;
  localparam int POS_UPDATED = 23;
  localparam int LOOP_W = 20;
  localparam int TX_RES_W = 16;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 20'hfffff;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // irq status bits: 0 tx update, 1 rx update, 2 loop update
  localparam int IRQ_W = 3;

  typedef struct packed {
    logic tx_valid;
    logic [TX_RES_W-1:0] tx_value;
    logic rx_valid;
    logic [RX_BUF_DEPTH-1:0] rx_value;
  } ext_meas_t;

  typedef enum logic [1:0] {
    LOOP_IDLE = 2'b00,
    LOOP_COUNT = 2'b01
  } loop_state_t;
endpackage

// ---- tb/link_delay_measurement_regs_tb_top.sv ----
// Purpose: self-checking bench for the link delay register bank
// Assumes: classic Wishbone, ack one cycle after the request edge
// Notes: measurement results and frame pulses driven on core_clk
`timescale 1ns/1ps
`default_nettype none
module link_delay_measurement_regs_tb_top import link_delay_pkg::*;;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, dat_o;
  logic ack, req, irq, ofs = 1'b0, lrc = 1'b0, txp = 1'b0, rxp = 1'b0;
  logic [3:0] fill = 4'h0;
  logic [7:0] txper, rxper;
  ext_meas_t em = '0;
  int fail_count = 0;
  int tests_run = 0;

  always #50 core_clk = ~core_clk;

  link_delay_measurement_regs link_delay_measurement_regs_i (
    .core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_fill_level(fill),
    .rx_byte_offset(ofs), .line_rate_changed(lrc),
    .rx_pointer_realign_req(req), .ext_meas(em), .tx_period(txper),
    .rx_period(rxper), .tx_frame_pulse(txp), .rx_frame_pulse(rxp),
    .irq(irq)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    // no local limit: a missing ack is caught by the watchdog
    do begin
      @(posedge core_clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk32(q, exp);
  endtask

  // tx pulse counts as cycle 0, rx pulse lands on cycle k
  task automatic frame(input int k);
    txp <= 1'b1;
    @(posedge core_clk);
    txp <= 1'b0;
    repeat (k - 1) @(posedge core_clk);
    rxp <= 1'b1;
    @(posedge core_clk);
    rxp <= 1'b0;
    @(posedge core_clk);
  endtask

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h4c + 8'(4 * i), 32'h0);
    end
    chk32({14'h0, irq, req, txper, rxper}, 32'h0);
    fill <= 4'hf;
    ofs <= 1'b1;
    wr(8'h4c, 32'hffff_ffff);
    chk1(req, 1'b1);
    rd_chk(8'h4c, 32'h0101_000f);
    wr(8'h4c, 32'h0);
    chk1(req, 1'b0);
    // rate change recovered without touching bit 24
    lrc <= 1'b1;
    @(posedge core_clk);
    chk1(req, 1'b1);
    lrc <= 1'b0;
    wr(8'h50, 32'hffff_ffff);
    wr(8'h54, 32'hffff_ffff);
    chk32({16'h0, txper, rxper}, 32'h0000_ffff);
    rd_chk(8'h50, 32'hff00_0000);
    em.tx_valid <= 1'b1;
    em.tx_value <= 16'h1234;
    em.rx_valid <= 1'b1;
    em.rx_value <= 4'h5;
    @(posedge core_clk);
    em.tx_valid <= 1'b0;
    em.rx_valid <= 1'b0;
    @(posedge core_clk);
    rd_chk(8'h50, 32'hff80_1234);
    rd_chk(8'h50, 32'hff00_1234);
    rd_chk(8'h54, 32'hff80_0005);
    rd_chk(8'h54, 32'hff00_0005);
    // a result landing on the read-clear edge keeps its flag
    fork
      rd_chk(8'h50, 32'hff00_1234);
      begin
        em.tx_valid <= 1'b1;
        em.tx_value <= 16'habcd;
        @(posedge core_clk);
        em.tx_valid <= 1'b0;
      end
    join
    rd_chk(8'h50, 32'hff80_abcd);
    frame(5);
    rd_chk(8'h58, 32'h0000_0005);
    wr(8'h58, 32'hffff_ffff);
    frame(37);
    rd_chk(8'h58, 32'h0000_0025);
    // all three events pending but masked
    chk1(irq, 1'b0);
    wr(8'h64, 32'hffff_ffff);
    rd_chk(8'h64, 32'h0000_0007);
    chk1(irq, 1'b1);
    rd_chk(8'h60, 32'h0000_0007);
    chk1(irq, 1'b0);
    wr(8'h70, 32'hffff_ffff);
    rd_chk(8'h70, 32'h0);
    wrap_up;
  end

  initial begin
    repeat (2000) @(posedge core_clk);
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up;
  end
endmodule // link_delay_measurement_regs_tb_top
`default_nettype wire
